// ==== pfi_program_flow.sv ====
// Program flow, loop and interrupt sequencing with APB registers
//
// The address map and the APB register port are this design's own decisions.
`timescale 1ns/1ps
module pfi_program_flow (
	input  wire logic              mclk,
	input  wire logic              srst,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [7:0]        paddr,
	input  wire logic [31:0]       pwdata,
	output logic      [31:0]       prdata,
	output logic                   pready,
	output logic                   pslverr,
	input  wire logic              instrValid,
	input  wire pfi_pkg::pfi_op_t   instrOp,
	input  wire pfi_pkg::pfi_cond_t instrCond,
	input  wire pfi_pkg::pfi_src_t  instrSrc,
	input  wire logic [7:0]        instrImm,
	input  wire logic [15:0]       instrReg,
	input  wire logic              instrLoopSel,
	input  wire logic [15:0]       accValue,
	input  wire logic              carryFlag,
	input  wire logic              equalsFlag,
	input  wire logic [7:0]        srcFlags,
	input  wire logic [7:0]        srcLocalEn,
	output logic      [15:0]       instrPointer,
	output logic                   instrReady,
	output logic                   irqEntry,
	output logic                   illegalOp,
	output logic                   inService
);
	pfi_stack_if stk ();

	logic [15:0] pc_q;
	logic [15:0] pc_d;
	logic [15:0] vector_q;
	logic [7:0]  prefix_q;
	logic [7:0]  mask_q;
	logic [7:0]  flags_q;
	logic        globalEn_q;
	logic        inService_q;
	logic        irqEntry_q;
	logic        illegal_q;
	logic [31:0] prdata_q;

	logic        zeroFlag;
	logic        signFlag;
	logic        condTrue;
	logic        srcBad;
	logic [15:0] target;
	logic [15:0] nextPtr;
	logic        irqReq;
	logic        doExec;
	logic        pushReq;
	logic        popReq;
	logic [15:0] pushData;
	logic        retiTaken;
	logic        illegalNow;
	logic        dec0;
	logic        dec1;
	logic [15:0] loop0;
	logic [15:0] loop1;
	logic        nz0;
	logic        nz1;

	logic        apbAccess;
	logic        apbWrite;
	logic        mapped;
	logic [31:0] readMux;
	logic        wrVector;
	logic        wrLoop0;
	logic        wrLoop1;
	logic        wrControl;
	logic        wrMask;
	logic        wrPrefix;

	// Status flags seen by conditions
	// zero flag from accumulator
	assign zeroFlag = (accValue == 16'h0000);
	assign signFlag = accValue[15];

	assign nextPtr = pc_q + 16'h0001;

	always_comb begin
		case (instrCond)
			pfi_pkg::CND_ALWAYS: condTrue = 1'b1;
			pfi_pkg::CND_C:      condTrue = carryFlag;
			pfi_pkg::CND_NC:     condTrue = ~carryFlag;
			pfi_pkg::CND_Z:      condTrue = zeroFlag;
			pfi_pkg::CND_NZ:     condTrue = ~zeroFlag;
			pfi_pkg::CND_S:      condTrue = signFlag;
			pfi_pkg::CND_E:      condTrue = equalsFlag;
			pfi_pkg::CND_NE:     condTrue = ~equalsFlag;
			default:             condTrue = 1'b0;
		endcase
	end

	assign srcBad = ((instrCond == pfi_pkg::CND_E) ||
		(instrCond == pfi_pkg::CND_NE)) &&
		((instrSrc == pfi_pkg::SRC_REG16) ||
		(instrSrc == pfi_pkg::SRC_REG8));

	// Branch target from the source operand
	always_comb begin
		case (instrSrc)
			pfi_pkg::SRC_REL:
				target = pc_q + {{8{instrImm[7]}}, instrImm};
			pfi_pkg::SRC_IMM:
				target = {prefix_q, instrImm};
			pfi_pkg::SRC_REG16:
				target = instrReg;
			pfi_pkg::SRC_REG8:
				target = {prefix_q, instrReg[7:0]};
			default:
				target = nextPtr;
		endcase
	end

	assign irqReq = globalEn_q && !inService_q &&
		|(flags_q & srcLocalEn & mask_q);

	// Interrupt entry takes the slot of the instruction
	assign instrReady = ~irqReq;
	assign doExec = instrValid && !irqReq;

	// Sequencing of pointer, stack and counters
	always_comb begin
		pc_d = pc_q;
		pushReq = 1'b0;
		popReq = 1'b0;
		pushData = nextPtr;
		retiTaken = 1'b0;
		illegalNow = 1'b0;
		dec0 = 1'b0;
		dec1 = 1'b0;
		if (irqReq) begin
			pushReq = 1'b1;
			pushData = pc_q;
			pc_d = vector_q;
		end else if (doExec) begin
			pc_d = nextPtr;
			case (instrOp)
				pfi_pkg::OP_JUMP: begin
					if (srcBad) begin
						illegalNow = 1'b1;
					end else if (condTrue) begin
						pc_d = target;
					end
				end
				pfi_pkg::OP_CALL: begin
					if (srcBad) begin
						illegalNow = 1'b1;
					end else if (condTrue) begin
						pushReq = 1'b1;
						pushData = nextPtr;
						pc_d = target;
					end
				end
				pfi_pkg::OP_RET,
				pfi_pkg::OP_RETI: begin
					if ((instrCond == pfi_pkg::CND_E) ||
						(instrCond == pfi_pkg::CND_NE)) begin
						illegalNow = 1'b1;
					end else if (condTrue) begin
						popReq = 1'b1;
						pc_d = stk.topData;
						retiTaken = (instrOp == pfi_pkg::OP_RETI);
					end
				end
				pfi_pkg::OP_DJNZ: begin
					dec0 = ~instrLoopSel;
					dec1 = instrLoopSel;
					if (instrLoopSel ? nz1 : nz0) begin
						pc_d = target;
					end
				end
				default: begin
					pc_d = nextPtr;
				end
			endcase
		end
	end

	// Instruction pointer
	always_ff @(posedge mclk) begin
		if (srst) begin
			pc_q <= pfi_pkg::PC_RST;
		end else begin
			pc_q <= pc_d;
		end
	end

	// Stack hookup
	assign stk.push = pushReq;
	assign stk.pop = popReq;
	assign stk.pushData = pushData;

	pfi_stack u_stack (
		.mclk (mclk),
		.srst (srst),
		.port (stk)
	);

	// Two loop counters
	pfi_loop_counter u_loop0 (
		.mclk       (mclk),
		.srst       (srst),
		.wrEn       (wrLoop0),
		.wrData     (pwdata[15:0]),
		.decEn      (dec0),
		.count      (loop0),
		.decNonZero (nz0)
	);

	pfi_loop_counter u_loop1 (
		.mclk       (mclk),
		.srst       (srst),
		.wrEn       (wrLoop1),
		.wrData     (pwdata[15:0]),
		.decEn      (dec1),
		.count      (loop1),
		.decNonZero (nz1)
	);

	// Prefix byte lasts one instruction
	// cleared after next instruction
	always_ff @(posedge mclk) begin
		if (srst) begin
			prefix_q <= pfi_pkg::PREFIX_RST;
		end else if (wrPrefix) begin
			prefix_q <= pwdata[7:0];
		end else if (doExec) begin
			if (instrOp == pfi_pkg::OP_PFX) begin
				prefix_q <= instrImm;
			end else begin
				prefix_q <= pfi_pkg::PREFIX_RST;
			end
		end
	end

	// handler return or software clears it
	always_ff @(posedge mclk) begin
		if (srst) begin
			inService_q <= 1'b0;
		end else if (irqReq) begin
			inService_q <= 1'b1;
		end else if (retiTaken) begin
			inService_q <= 1'b0;
		end else if (wrControl) begin
			inService_q <= pwdata[pfi_pkg::CTL_INSERV_BIT];
		end
	end

	// flags follow the modules, not writable
	always_ff @(posedge mclk) begin
		if (srst) begin
			flags_q <= 8'h00;
		end else begin
			flags_q <= srcFlags;
		end
	end

	// Software written control state
	always_ff @(posedge mclk) begin
		if (srst) begin
			vector_q <= pfi_pkg::VECTOR_RST;
			mask_q <= pfi_pkg::MASK_RST;
			globalEn_q <= 1'b0;
		end else begin
			if (wrVector) begin
				vector_q <= pwdata[15:0];
			end
			if (wrMask) begin
				mask_q <= pwdata[7:0];
			end
			if (wrControl) begin
				globalEn_q <= pwdata[pfi_pkg::CTL_GLOBAL_BIT];
			end
		end
	end

	// Event pulses for the core
	always_ff @(posedge mclk) begin
		if (srst) begin
			irqEntry_q <= 1'b0;
			illegal_q <= 1'b0;
		end else begin
			irqEntry_q <= irqReq;
			illegal_q <= illegalNow;
		end
	end

	// APB decode
	assign apbAccess = psel && penable;
	assign apbWrite = apbAccess && pwrite && mapped;
	assign wrVector = apbWrite && (paddr == pfi_pkg::OFS_VECTOR);
	assign wrLoop0 = apbWrite && (paddr == pfi_pkg::OFS_LOOP0);
	assign wrLoop1 = apbWrite && (paddr == pfi_pkg::OFS_LOOP1);
	assign wrControl = apbWrite && (paddr == pfi_pkg::OFS_CONTROL);
	assign wrMask = apbWrite && (paddr == pfi_pkg::OFS_MASK);
	assign wrPrefix = apbWrite && (paddr == pfi_pkg::OFS_PREFIX);

	// Read multiplexer, unmapped reads as zero
	always_comb begin
		mapped = 1'b1;
		readMux = 32'h0000_0000;
		case (paddr)
			pfi_pkg::OFS_VECTOR:   readMux[15:0] = vector_q;
			pfi_pkg::OFS_LOOP0:    readMux[15:0] = loop0;
			pfi_pkg::OFS_LOOP1:    readMux[15:0] = loop1;
			pfi_pkg::OFS_CONTROL: begin
				readMux[pfi_pkg::CTL_GLOBAL_BIT] = globalEn_q;
				readMux[pfi_pkg::CTL_INSERV_BIT] = inService_q;
			end
			pfi_pkg::OFS_MASK:     readMux[7:0] = mask_q;
			pfi_pkg::OFS_FLAGS:    readMux[7:0] = flags_q;
			pfi_pkg::OFS_PREFIX:   readMux[7:0] = prefix_q;
			pfi_pkg::OFS_NEXTPTR:  readMux[15:0] = nextPtr;
			pfi_pkg::OFS_STACKPTR: readMux[3:0] = stk.topPtr;
			pfi_pkg::OFS_STATUS: begin
				readMux[0] = zeroFlag;
				readMux[1] = signFlag;
			end
			default:               mapped = 1'b0;
		endcase
	end

	// Read data captured in the setup cycle
	always_ff @(posedge mclk) begin
		if (srst) begin
			prdata_q <= 32'h0000_0000;
		end else if (psel && !penable) begin
			prdata_q <= readMux;
		end
	end

	assign prdata = prdata_q;
	assign pready = 1'b1;
	assign pslverr = apbAccess && !mapped;
	assign instrPointer = pc_q;
	assign irqEntry = irqEntry_q;
	assign illegalOp = illegal_q;
	assign inService = inService_q;
endmodule

// ==== pfi_pkg.sv ====
// Constants and types of the program flow and interrupt unit
// Overview of operation
// - Reading the next pointer returns current address plus one.
// - Relative branch adds a signed 8-bit word offset to the pointer.
// - Absolute targets: 8-bit immediate, 16-bit register, or 8-bit register.
// - An 8-bit register target takes the prefix as its high byte.
// - Conditional branch taken only when the chosen flag condition holds.
// - Equals and not-equals branches accept relative and immediate destinations only.
// - Call pushes the next address, then branches like a jump.
// - Return pops and resumes; handler return also ends service.
// - Two 16-bit loop counters; decrement, branch while result nonzero.
// - Far loop addresses take their high byte from the prefix.
// - A 16-bit register loop address needs no prefix cycle.
// - Conditional return pops when true, else just steps to the next address.
// - One 16-bit handler vector, reset zero, used by every interrupt.
// - Interrupt needs global, module mask and local enable all set.
// - Handler entry sets in-service, blocking further interrupts.
// - Handler return clears in-service; software may clear it too.
// - Per-module pending flags, read only, follow the modules' flags.
// - Mask bit zero blocks requests but not the pending flag.
// - Conditional handler return pops and clears service only when true.
// - Push increments pointer then writes; pop reads then decrements.
// - Zero flag is one exactly when the accumulator is all zero.
package pfi_pkg;
	localparam int ADDR_W = 16;
	localparam int MOD_N = 8;
	localparam int STACK_AW = 4;
	localparam int STACK_DEPTH = 16;

	// Register byte offsets on the bus
	localparam logic [7:0] OFS_VECTOR = 8'h00;
	localparam logic [7:0] OFS_LOOP0 = 8'h04;
	localparam logic [7:0] OFS_LOOP1 = 8'h08;
	localparam logic [7:0] OFS_CONTROL = 8'h0C;
	localparam logic [7:0] OFS_MASK = 8'h10;
	localparam logic [7:0] OFS_FLAGS = 8'h14;
	localparam logic [7:0] OFS_PREFIX = 8'h18;
	localparam logic [7:0] OFS_NEXTPTR = 8'h1C;
	localparam logic [7:0] OFS_STACKPTR = 8'h20;
	localparam logic [7:0] OFS_STATUS = 8'h24;

	// Control register fields
	localparam int CTL_GLOBAL_BIT = 0;
	localparam int CTL_INSERV_BIT = 1;

	// Values after reset
	localparam logic [15:0] VECTOR_RST = 16'h0000;
	localparam logic [15:0] LOOP_RST = 16'h0000;
	localparam logic [15:0] PC_RST = 16'h0000;
	localparam logic [7:0] PREFIX_RST = 8'h00;
	localparam logic [7:0] MASK_RST = 8'h00;
	localparam logic [3:0] SP_RST = 4'hF;

	typedef enum logic [2:0] {
		OP_NOP, OP_JUMP, OP_CALL, OP_RET, OP_RETI, OP_DJNZ, OP_PFX
	} pfi_op_t;

	typedef enum logic [2:0] {
		CND_ALWAYS, CND_C, CND_NC, CND_Z, CND_NZ, CND_S, CND_E, CND_NE
	} pfi_cond_t;

	typedef enum logic [1:0] {
		SRC_REL, SRC_IMM, SRC_REG16, SRC_REG8
	} pfi_src_t;
endpackage

// ==== pfi_stack_if.sv ====
// Carrier between the flow unit and the hardware stack
`timescale 1ns/1ps
interface pfi_stack_if;
	logic        push;
	logic        pop;
	logic [15:0] pushData;
	logic [15:0] topData;
	logic [3:0]  topPtr;

	modport user (output push, output pop, output pushData,
		input topData, input topPtr);
	modport store (input push, input pop, input pushData,
		output topData, output topPtr);
endinterface

// ==== pfi_loop_counter.sv ====
// One 16-bit loop counter with load and decrement
`timescale 1ns/1ps
module pfi_loop_counter (
	input  wire logic        mclk,
	input  wire logic        srst,
	input  wire logic        wrEn,
	input  wire logic [15:0] wrData,
	input  wire logic        decEn,
	output logic      [15:0] count,
	output logic             decNonZero
);
	logic [15:0] count_q;

	// Load from software wins over decrement
	always_ff @(posedge mclk) begin
		if (srst) begin
			count_q <= pfi_pkg::LOOP_RST;
		end else if (wrEn) begin
			count_q <= wrData;
		end else if (decEn) begin
			count_q <= count_q - 16'h0001;
		end
	end

	assign count = count_q;
	// Result after decrement is not zero
	assign decNonZero = (count_q != 16'h0001);
endmodule

// ==== pfi_stack.sv ====
// Sixteen-word hardware stack of 16-bit entries
`timescale 1ns/1ps
module pfi_stack (
	input wire logic mclk,
	input wire logic srst,
	pfi_stack_if.store port
);
	logic [15:0] mem_q [pfi_pkg::STACK_DEPTH];
	logic [3:0]  sp_q;
	logic [3:0]  spInc;

	assign spInc = sp_q + 4'h1;

	always_ff @(posedge mclk) begin
		if (srst) begin
			sp_q <= pfi_pkg::SP_RST;
		end else if (port.push) begin
			sp_q <= spInc;
		end else if (port.pop) begin
			sp_q <= sp_q - 4'h1;
		end
	end

	// Storage written at the incremented slot
	always_ff @(posedge mclk) begin
		if (port.push) begin
			mem_q[spInc] <= port.pushData;
		end
	end

	assign port.topData = mem_q[sp_q];
	assign port.topPtr = sp_q;
endmodule

// ==== pfi_program_flow_properties.sv ====
// Port checker for the program flow unit, bound to its top
`timescale 1ns/1ps
module pfi_flow_checker (
	input wire logic               mclk,
	input wire logic               srst,
	input wire logic               instrValid,
	input wire pfi_pkg::pfi_op_t   instrOp,
	input wire pfi_pkg::pfi_cond_t instrCond,
	input wire pfi_pkg::pfi_src_t  instrSrc,
	input wire logic [7:0]         instrImm,
	input wire logic [15:0]        instrReg,
	input wire logic               carryFlag,
	input wire logic [15:0]        instrPointer,
	input wire logic               instrReady,
	input wire logic               irqEntry,
	input wire logic               illegalOp,
	input wire logic               inService
);
	logic        go;
	logic        jmpAlw;
	logic [15:0] nextPc;

	// Executed instruction qualifiers
	assign go = instrValid && instrReady;
	assign jmpAlw = go && instrOp == pfi_pkg::OP_JUMP
		&& instrCond == pfi_pkg::CND_ALWAYS;
	assign nextPc = instrPointer + 16'h0001;

	default clocking cb @(posedge mclk); endclocking
	default disable iff (srst);

	a_seq_step: assert property (
		go && instrOp == pfi_pkg::OP_NOP |=> instrPointer == $past(nextPc))
		else $error("pointer did not step");
	a_rel_jump: assert property (
		jmpAlw && instrSrc == pfi_pkg::SRC_REL |=> instrPointer ==
		$past(instrPointer) + {{8{$past(instrImm[7])}}, $past(instrImm)})
		else $error("relative target wrong");
	a_reg_jump: assert property (
		jmpAlw && instrSrc == pfi_pkg::SRC_REG16
		|=> instrPointer == $past(instrReg))
		else $error("register target wrong");
	a_equals_imm: assert property (
		go && instrOp == pfi_pkg::OP_JUMP
		&& instrCond inside {pfi_pkg::CND_E, pfi_pkg::CND_NE}
		&& instrSrc inside {pfi_pkg::SRC_REG16, pfi_pkg::SRC_REG8}
		|=> illegalOp && instrPointer == $past(nextPc))
		else $error("equals jump took a register");
	a_carry_false: assert property (
		go && instrOp == pfi_pkg::OP_JUMP && instrCond == pfi_pkg::CND_C
		&& !carryFlag |=> instrPointer == $past(nextPc))
		else $error("false carry jump taken");
	a_ret_false: assert property (
		go && instrOp == pfi_pkg::OP_RET && instrCond == pfi_pkg::CND_NC
		&& carryFlag |=> instrPointer == $past(nextPc))
		else $error("false return moved pointer");
	a_entry_sets: assert property (
		!instrReady |=> irqEntry && inService)
		else $error("entry without service bit");
	a_no_nest: assert property (
		inService |-> instrReady)
		else $error("request while in service");
	a_reti_clear: assert property (
		go && instrOp == pfi_pkg::OP_RETI
		&& instrCond == pfi_pkg::CND_ALWAYS |=> !inService)
		else $error("handler return kept service");
endmodule

bind pfi_program_flow pfi_flow_checker u_chk (.mclk, .srst, .instrValid,
	.instrOp, .instrCond, .instrSrc, .instrImm, .instrReg, .carryFlag,
	.instrPointer, .instrReady, .irqEntry, .illegalOp, .inService);

// ==== pfi_program_flow_tb.sv ====
// Self-checking bench for the program flow unit
`timescale 1ns/1ps
module pfi_program_flow_tb;
	typedef struct packed {
		logic [2:0]  c;
		logic [1:0]  s;
		logic [7:0]  i;
		logic [15:0] r;
		logic [15:0] a;
		logic        y;
		logic        e;
		logic        t;
	} pfi_row_t;

	logic               mclk;
	logic               srst = 1'b1;
	logic               psel = 1'b0;
	logic               penable = 1'b0;
	logic               pwrite = 1'b0;
	logic [7:0]         paddr = 8'h00;
	logic [31:0]        pwdata = 32'h0000_0000;
	logic [31:0]        prdata;
	logic               pready;
	logic               pslverr;
	logic               instrValid = 1'b0;
	pfi_pkg::pfi_op_t   instrOp = pfi_pkg::OP_NOP;
	pfi_pkg::pfi_cond_t instrCond = pfi_pkg::CND_ALWAYS;
	pfi_pkg::pfi_src_t  instrSrc = pfi_pkg::SRC_REL;
	logic [7:0]         instrImm = 8'h00;
	logic [15:0]        instrReg = 16'h0000;
	logic               instrLoopSel = 1'b0;
	logic [15:0]        accValue = 16'h0001;
	logic               carryFlag = 1'b0;
	logic               equalsFlag = 1'b0;
	logic [7:0]         srcFlags = 8'h00;
	logic [7:0]         srcLocalEn = 8'h00;
	logic [15:0]        instrPointer;
	logic               instrReady;
	logic               irqEntry;
	logic               illegalOp;
	logic               inService;
	logic [31:0]        rdVal;
	logic               errVal;
	logic [15:0]        ePc = 16'h0000;
	pfi_row_t           w;
	int                 fails = 0;
	int                 nCompared = 0;

	// Cond, source, imm, reg, acc, carry, equals, taken
	pfi_row_t rows [11] = '{
		'{3'h0, 2'h0, 8'h7F, 16'h0000, 16'h0001, 1'b0, 1'b0, 1'b1},
		'{3'h0, 2'h0, 8'h80, 16'h0000, 16'h0001, 1'b0, 1'b0, 1'b1},
		'{3'h1, 2'h1, 8'h44, 16'h0000, 16'h0001, 1'b1, 1'b0, 1'b1},
		'{3'h1, 2'h1, 8'h45, 16'h0000, 16'h0001, 1'b0, 1'b0, 1'b0},
		'{3'h2, 2'h1, 8'h50, 16'h0000, 16'h0001, 1'b0, 1'b0, 1'b1},
		'{3'h3, 2'h2, 8'h00, 16'h1234, 16'h0000, 1'b0, 1'b0, 1'b1},
		'{3'h4, 2'h0, 8'h10, 16'h0000, 16'h0000, 1'b0, 1'b0, 1'b0},
		'{3'h4, 2'h1, 8'h20, 16'h0000, 16'h8000, 1'b0, 1'b0, 1'b1},
		'{3'h5, 2'h3, 8'h00, 16'h0CAB, 16'h8000, 1'b0, 1'b0, 1'b1},
		'{3'h6, 2'h1, 8'h66, 16'h0000, 16'h0001, 1'b0, 1'b1, 1'b1},
		'{3'h7, 2'h1, 8'h77, 16'h0000, 16'h0001, 1'b0, 1'b1, 1'b0}};

	pfi_program_flow u_dut (.mclk, .srst, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .instrValid, .instrOp,
		.instrCond, .instrSrc, .instrImm, .instrReg, .instrLoopSel,
		.accValue, .carryFlag, .equalsFlag, .srcFlags, .srcLocalEn,
		.instrPointer, .instrReady, .irqEntry, .illegalOp, .inService);

	// Clock of 10 ns
	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end

	// Branch target with a zero prefix
	function automatic logic [15:0] dest(pfi_row_t q, logic [15:0] pc);
		case (q.s)
			2'h0: dest = pc + {{8{q.i[7]}}, q.i};
			2'h1: dest = {8'h00, q.i};
			2'h2: dest = q.r;
			default: dest = {8'h00, q.r[7:0]};
		endcase
	endfunction

	task automatic tallyAndFinish;
		$display("compared %0d, mismatches %0d", nCompared, fails);
		if (fails == 0 && nCompared > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	task automatic hang;
		fails++;
		$display("ERROR %0t: wait timed out", $time);
		tallyAndFinish();
	endtask

	task automatic chk(logic [31:0] got, logic [31:0] exp);
		nCompared++;
		if (got !== exp) begin
			fails++;
			$display("ERROR %0t: got %h want %h", $time, got, exp);
		end
	endtask

	task automatic chkPc(logic [15:0] exp);
		chk({16'h0000, instrPointer}, {16'h0000, exp});
	endtask

	task automatic chkB(logic got, logic exp);
		chk({31'h0000_0000, got}, {31'h0000_0000, exp});
	endtask

	// One bus transfer, held until ready is seen
	task automatic apb(logic wr, logic [7:0] a, logic [31:0] d = 0);
		bit ok;
		ok = 0;
		@(posedge mclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		for (int n = 0; n < 16 && !ok; n++) begin
			@(posedge mclk);
			ok = pready;
			rdVal = prdata;
			errVal = pslverr;
		end
		if (!ok) hang();
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// One instruction, re-presented until accepted
	task automatic ex(pfi_pkg::pfi_op_t op, logic [2:0] c = 0,
		logic [1:0] s = 0, logic [7:0] i = 0, logic [15:0] r = 0,
		logic l = 0, logic [15:0] a = 1, logic y = 0, logic e = 0);
		bit ok;
		ok = 0;
		@(posedge mclk);
		instrValid <= 1'b1;
		instrOp <= op;
		instrCond <= pfi_pkg::pfi_cond_t'(c);
		instrSrc <= pfi_pkg::pfi_src_t'(s);
		instrImm <= i;
		instrReg <= r;
		instrLoopSel <= l;
		accValue <= a;
		carryFlag <= y;
		equalsFlag <= e;
		// Ready sampled at the rising edge that takes the instruction
		for (int n = 0; n < 16 && !ok; n++) begin
			@(posedge mclk);
			ok = instrReady;
		end
		if (!ok) hang();
		instrValid <= 1'b0;
		@(negedge mclk);
	endtask

	// Main sequence
	initial begin
		repeat (10) @(posedge mclk);
		srst <= 1'b0;
		apb(1'b0, pfi_pkg::OFS_VECTOR);
		chk(rdVal, 32'h0000_0000);
		apb(1'b0, pfi_pkg::OFS_STACKPTR);
		chk(rdVal, 32'h0000_000F);
		apb(1'b0, pfi_pkg::OFS_NEXTPTR);
		chk(rdVal, 32'h0000_0001);
		$display("reset test done");
		foreach (rows[k]) begin
			w = rows[k];
			ePc = w.t ? dest(w, ePc) : ePc + 16'h0001;
			ex(pfi_pkg::OP_JUMP, w.c, w.s, w.i, w.r, 1'b0, w.a, w.y, w.e);
			chkPc(ePc);
		end
		$display("branch rows done");
		ex(pfi_pkg::OP_PFX, 3'h0, 2'h0, 8'h12);
		ex(pfi_pkg::OP_JUMP, 3'h0, 2'h3, 8'h00, 16'hFF34);
		chkPc(16'h1234);
		ex(pfi_pkg::OP_JUMP, 3'h0, 2'h3, 8'h00, 16'h0056);
		chkPc(16'h0056);
		ex(pfi_pkg::OP_JUMP, 3'h6, 2'h2, 8'h00, 16'h0999);
		chkB(illegalOp, 1'b1);
		chkPc(16'h0057);
		apb(1'b0, pfi_pkg::OFS_NEXTPTR);
		chk(rdVal, 32'h0000_0058);
		$display("prefix test done");
		ex(pfi_pkg::OP_CALL, 3'h0, 2'h2, 8'h00, 16'h0400);
		chkPc(16'h0400);
		apb(1'b0, pfi_pkg::OFS_STACKPTR);
		chk(rdVal, 32'h0000_0000);
		ex(pfi_pkg::OP_RET, 3'h2, 2'h0, 8'h00, 16'h0000, 1'b0, 16'h1, 1'b1);
		chkPc(16'h0401);
		ex(pfi_pkg::OP_RET);
		chkPc(16'h0058);
		apb(1'b0, pfi_pkg::OFS_STACKPTR);
		chk(rdVal, 32'h0000_000F);
		$display("call test done");
		apb(1'b1, pfi_pkg::OFS_LOOP1, 32'h0000_0002);
		ex(pfi_pkg::OP_DJNZ, 3'h0, 2'h0, 8'hFE, 16'h0000, 1'b1);
		chkPc(16'h0056);
		ex(pfi_pkg::OP_DJNZ, 3'h0, 2'h0, 8'hFE, 16'h0000, 1'b1);
		chkPc(16'h0057);
		apb(1'b1, pfi_pkg::OFS_LOOP0, 32'h0000_0003);
		ex(pfi_pkg::OP_PFX, 3'h0, 2'h0, 8'h30);
		ex(pfi_pkg::OP_DJNZ, 3'h0, 2'h1, 8'h10);
		chkPc(16'h3010);
		ex(pfi_pkg::OP_DJNZ, 3'h0, 2'h2, 8'h00, 16'h0777);
		chkPc(16'h0777);
		apb(1'b0, pfi_pkg::OFS_LOOP0);
		chk(rdVal, 32'h0000_0001);
		$display("loop test done");
		apb(1'b1, pfi_pkg::OFS_VECTOR, 32'h0000_0200);
		srcLocalEn <= 8'h01;
		srcFlags <= 8'h01;
		apb(1'b1, pfi_pkg::OFS_CONTROL, 32'h0000_0001);
		ex(pfi_pkg::OP_NOP);
		chkB(inService, 1'b0);
		apb(1'b1, pfi_pkg::OFS_FLAGS);
		apb(1'b0, pfi_pkg::OFS_FLAGS);
		chk(rdVal, 32'h0000_0001);
		apb(1'b1, pfi_pkg::OFS_MASK, 32'h0000_0001);
		ex(pfi_pkg::OP_NOP);
		chkPc(16'h0201);
		chkB(inService, 1'b1);
		ex(pfi_pkg::OP_RETI, 3'h1);
		chkPc(16'h0202);
		@(posedge mclk);
		srcFlags <= 8'h00;
		ex(pfi_pkg::OP_RETI);
		chkPc(16'h0778);
		chkB(inService, 1'b0);
		apb(1'b0, pfi_pkg::OFS_FLAGS);
		chk(rdVal, 32'h0000_0000);
		srcLocalEn <= 8'h00;
		srcFlags <= 8'h01;
		ex(pfi_pkg::OP_NOP);
		chkB(inService, 1'b0);
		@(posedge mclk);
		srcLocalEn <= 8'h01;
		ex(pfi_pkg::OP_NOP);
		chkPc(16'h0201);
		chkB(inService, 1'b1);
		@(posedge mclk);
		srcFlags <= 8'h00;
		apb(1'b1, pfi_pkg::OFS_CONTROL, 32'h0000_0001);
		apb(1'b0, pfi_pkg::OFS_CONTROL);
		chk(rdVal, 32'h0000_0001);
		ex(pfi_pkg::OP_RETI);
		chkPc(16'h0779);
		apb(1'b0, 8'hF0);
		chkB(errVal, 1'b1);
		$display("interrupt test done");
		@(posedge mclk);
		srst <= 1'b1;
		repeat (2) @(posedge mclk);
		srst <= 1'b0;
		apb(1'b0, pfi_pkg::OFS_VECTOR);
		chk(rdVal, 32'h0000_0000);
		apb(1'b0, pfi_pkg::OFS_NEXTPTR);
		chk(rdVal, 32'h0000_0001);
		$display("mid-run reset test done");
		tallyAndFinish();
	end
endmodule
